//--- include/pco_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Fast parallel-detect link-up set selects the short link timer.
// - Fast or robust crossover mode in option register A forces bit 6 on.
// - Extended full duplex forces full duplex against a forced-100 partner in AN or forced-100 mode.
// - Extended full duplex clear leaves duplex to the standard resolution.
// - Strict link indicator lights only on a 100 Mb/s full-duplex link.
// - Strict link indicator suppresses activity blinking of the indicator.
// - Isolate-on-half-duplex tristates MAC outputs on a 100 Mb/s HD link.
// - Idle symbol errors are reported only while bit 2 is set (reset 1).
// - Odd-nibble TX_EN drop is stretched one nibble with TX_ER asserted.
// - Odd-nibble disable set flags no error for an odd-nibble drop.
// - RMII receive data follows RX_CLK when bit 0 is set, else crystal.
//////////////////////////////////////////////////////////////////////////////
package pco_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_OPT_A   = 8'h09;
    localparam logic [7:0]  IDX_OPT_B   = 8'h0a;
    localparam logic [7:0]  IDX_GEN_CTL = 8'h19;
    localparam logic [7:0]  IDX_STATUS  = 8'h20;
    // Option register B fields
    localparam int FAST_PD_BIT   = 6;
    localparam int EXT_FD_BIT    = 5;
    localparam int STRICT_BIT    = 4;
    localparam int ISO_HD_BIT    = 3;
    localparam int IDLE_ERR_BIT  = 2;
    localparam int ODD_DIS_BIT   = 1;
    localparam int RMII_CLK_BIT  = 0;
    localparam logic [15:0] OPT_B_RST   = 16'h0104;
    // Option register A crossover fields, general control blink field
    localparam int FAST_MDIX_BIT  = 6;
    localparam int ROBUST_MDIX_BIT = 5;
    localparam logic [15:0] OPT_A_RST   = 16'h0000;
    localparam int BLINK_BIT      = 5;
    localparam logic [15:0] GEN_CTL_RST = 16'h0000;
    // Timing
    localparam int CLK_MHZ        = 250;
    localparam int PD_NORMAL_US   = 1000;
    localparam int PD_FAST_US     = 100;
    localparam int BLINK_HALF_US  = 50000;
    localparam int PD_NORMAL_CYC  = PD_NORMAL_US * CLK_MHZ;
    localparam int PD_FAST_CYC    = PD_FAST_US * CLK_MHZ;
    localparam int BLINK_HALF_CYC = BLINK_HALF_US * CLK_MHZ;
    // Bus access states
    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ  = 2'b10
    } pco_bus_e;
endpackage

//--- include/pco_opt_if.sv
interface pco_opt_if;
    logic odd_det_dis;
    logic tx_stb;
    modport ctl (output odd_det_dis, output tx_stb);
    modport nib (input odd_det_dis, input tx_stb);
endinterface

//--- logic/pco_tx_nibble.sv
module pco_tx_nibble
    import pco_pkg::*;
(
    // Clocking
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic ce,
    // Options
    pco_opt_if.nib    opt,
    // Transmit path
    input  wire logic tx_en_in,
    input  wire logic tx_er_in,
    output logic      tx_en_q,
    output logic      tx_er_q
);
    logic odd_q;
    logic ext_q;

    // Parity of nibbles seen so far in the frame
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            odd_q <= 1'b0;
        end else if (ce && opt.tx_stb) begin
            odd_q <= tx_en_in ? ~odd_q : 1'b0;
        end
    end

    // One stretched nibble with error forced
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ext_q   <= 1'b0;
            tx_en_q <= 1'b0;
            tx_er_q <= 1'b0;
        end else if (ce && opt.tx_stb) begin
            ext_q <= 1'b0;
            if (!tx_en_in && tx_en_q && odd_q && !opt.odd_det_dis
                && !ext_q) begin
                ext_q   <= 1'b1;
                tx_en_q <= 1'b1;
                tx_er_q <= 1'b1;
            end else begin
                tx_en_q <= tx_en_in;
                tx_er_q <= tx_er_in & tx_en_in;
            end
        end
    end
endmodule // pco_tx_nibble

//--- logic/pco_top.sv
module pco_top
    import pco_pkg::*;
#(
    parameter int PD_NORMAL_CYCLES = PD_NORMAL_CYC,
    parameter int PD_FAST_CYCLES   = PD_FAST_CYC,
    parameter int BLINK_CYCLES     = BLINK_HALF_CYC
)(
    // Clocking
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Link resolution
    input  wire logic        pd_signal_ok,
    input  wire logic        an_mode,
    input  wire logic        forced_100,
    input  wire logic        partner_forced_100,
    input  wire logic        ieee_full_duplex,
    input  wire logic        link_up,
    input  wire logic        link_100,
    input  wire logic        activity,
    output logic             pd_link_ok,
    output logic             full_duplex,
    output logic             link_led,
    // Receive path
    input  wire logic        rx_sym_err,
    input  wire logic        rx_idle,
    input  wire logic        rx_dv_in,
    input  wire logic        rx_er_in,
    input  wire logic [3:0]  rxd_in,
    input  wire logic        crs_in,
    input  wire logic        col_in,
    input  wire logic        rmii_mode,
    input  wire logic [1:0]  rmii_rxd_xi,
    input  wire logic [1:0]  rmii_rxd_rxclk,
    output logic             mac_rx_dv,
    output logic             mac_rx_er,
    output logic [3:0]       mac_rxd,
    output logic             mac_crs,
    output logic             mac_col,
    output logic             mac_out_oe,
    // Transmit path
    input  wire logic        tx_stb,
    input  wire logic        tx_en_in,
    input  wire logic        tx_er_in,
    output logic             tx_en_out,
    output logic             tx_er_out
);
    //////////////////////////////////////////////////////////////////////////
    localparam logic [31:0] PD_NORM_W  = 32'(PD_NORMAL_CYCLES - 1);
    localparam logic [31:0] PD_FAST_W  = 32'(PD_FAST_CYCLES - 1);
    localparam logic [31:0] BLINK_W    = 32'(BLINK_CYCLES - 1);

    pco_bus_e    bus_q;
    logic [7:0]  idx_q;
    logic        word_q;
    logic        rd_wait_q;
    logic [31:0] hrdata_q;
    logic [15:0] opt_a_q;
    logic [15:0] opt_b_q;
    logic [15:0] gen_q;
    logic        auto_fast;
    logic        take;
    logic [31:0] pd_cnt_q;
    logic        pd_link_q;
    logic [31:0] blink_cnt_q;
    logic        blink_q;
    logic        fd_q;
    logic        led_q;
    logic        iso;
    logic        mac_rx_dv_q;
    logic        mac_rx_er_q;
    logic [3:0]  mac_rxd_q;
    logic        mac_crs_q;
    logic        mac_col_q;
    logic        oe_q;
    logic [1:0]  rmii_q;

    pco_opt_if opt_bus ();

    // Register index of a byte address, all-ones when misaligned
    function automatic logic [7:0] reg_index(input logic [31:0] a);
        if (a[1:0] != 2'b00 || a[31:10] != 22'h0) begin
            return 8'hff;
        end else begin
            return a[9:2];
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Bus slave: writes zero-wait, reads take one wait state so a read
    // straight after a write returns the freshly written value
    assign take      = hsel && htrans[1] && hready;
    assign hreadyout = ~rd_wait_q;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_q  <= BUS_IDLE;
            idx_q  <= 8'h00;
            word_q <= 1'b0;
        end else if (ce) begin
            if (take) begin
                bus_q  <= hwrite ? BUS_WRITE : BUS_READ;
                idx_q  <= reg_index(haddr);
                word_q <= (hsize == 3'b010);
            end else if (hreadyout) begin
                bus_q <= BUS_IDLE;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_wait_q <= 1'b0;
        end else if (ce) begin
            rd_wait_q <= take && !hwrite;
        end
    end

    // Read mux; unmapped indices read as zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hrdata_q <= 32'h0;
        end else if (ce && rd_wait_q) begin
            if (idx_q == IDX_OPT_A) begin
                hrdata_q <= {16'h0, opt_a_q};
            end else if (idx_q == IDX_OPT_B) begin
                hrdata_q <= {16'h0, opt_b_q};
            end else if (idx_q == IDX_GEN_CTL) begin
                hrdata_q <= {16'h0, gen_q};
            end else if (idx_q == IDX_STATUS) begin
                hrdata_q <= {25'h0, oe_q, rmii_q[0], blink_q, led_q,
                             fd_q, pd_link_q, link_up};
            end else begin
                hrdata_q <= 32'h0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Option registers; only whole-word writes are accepted
    assign auto_fast = opt_a_q[FAST_MDIX_BIT] | opt_a_q[ROBUST_MDIX_BIT];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            opt_a_q <= OPT_A_RST;
            gen_q   <= GEN_CTL_RST;
        end else if (ce && bus_q == BUS_WRITE && word_q) begin
            if (idx_q == IDX_OPT_A) begin
                opt_a_q <= hwdata[15:0];
            end else if (idx_q == IDX_GEN_CTL) begin
                gen_q <= hwdata[15:0];
            end
        end
    end

    // Crossover modes set the fast link-up bit; the set wins over a write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            opt_b_q <= OPT_B_RST;
        end else if (ce) begin
            if (bus_q == BUS_WRITE && word_q && idx_q == IDX_OPT_B) begin
                opt_b_q <= hwdata[15:0];
            end
            if (auto_fast) begin
                opt_b_q[FAST_PD_BIT] <= 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Parallel detect link timer; limit follows the live option bit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pd_cnt_q  <= 32'h0;
            pd_link_q <= 1'b0;
        end else if (ce) begin
            if (!pd_signal_ok) begin
                pd_cnt_q  <= 32'h0;
                pd_link_q <= 1'b0;
            end else if (pd_cnt_q >= (opt_b_q[FAST_PD_BIT] ? PD_FAST_W
                                                          : PD_NORM_W)) begin
                pd_link_q <= 1'b1;
            end else begin
                pd_cnt_q <= pd_cnt_q + 32'h1;
            end
        end
    end
    assign pd_link_ok = pd_link_q;

    //////////////////////////////////////////////////////////////////////////
    // Duplex resolution
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fd_q <= 1'b0;
        end else if (ce) begin
            if (opt_b_q[EXT_FD_BIT] && (an_mode || forced_100)
                && partner_forced_100) begin
                fd_q <= 1'b1;
            end else begin
                fd_q <= ieee_full_duplex;
            end
        end
    end
    assign full_duplex = fd_q;

    //////////////////////////////////////////////////////////////////////////
    // Link indicator with optional activity blink
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            blink_cnt_q <= 32'h0;
            blink_q     <= 1'b0;
        end else if (ce) begin
            if (!activity) begin
                blink_cnt_q <= 32'h0;
                blink_q     <= 1'b0;
            end else if (blink_cnt_q >= BLINK_W) begin
                blink_cnt_q <= 32'h0;
                blink_q     <= ~blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            led_q <= 1'b0;
        end else if (ce) begin
            if (opt_b_q[STRICT_BIT]) begin
                // Blink setting ignored here
                led_q <= link_up && link_100 && fd_q;
            end else begin
                led_q <= link_up && !(gen_q[BLINK_BIT] && blink_q);
            end
        end
    end
    assign link_led = led_q;

    //////////////////////////////////////////////////////////////////////////
    // MAC-side receive outputs, isolated on a half-duplex 100 Mb/s link
    assign iso = opt_b_q[ISO_HD_BIT] && link_up && link_100 && !fd_q;

    // Data sampled from the chosen RMII reference; both arrive in-domain
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rmii_q <= 2'b00;
        end else if (ce) begin
            rmii_q <= opt_b_q[RMII_CLK_BIT] ? rmii_rxd_rxclk
                                            : rmii_rxd_xi;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            oe_q        <= 1'b0;
            mac_rx_dv_q <= 1'b0;
            mac_rx_er_q <= 1'b0;
            mac_rxd_q   <= 4'h0;
            mac_crs_q   <= 1'b0;
            mac_col_q   <= 1'b0;
        end else if (ce) begin
            oe_q <= ~iso;
            if (iso) begin
                mac_rx_dv_q <= 1'b0;
                mac_rx_er_q <= 1'b0;
                mac_rxd_q   <= 4'h0;
                mac_crs_q   <= 1'b0;
                mac_col_q   <= 1'b0;
            end else begin
                mac_rx_dv_q <= rx_dv_in;
                // Idle symbol errors pass only when enabled
                mac_rx_er_q <= rx_er_in || (rx_idle && rx_sym_err
                               && opt_b_q[IDLE_ERR_BIT]);
                mac_rxd_q   <= rmii_mode ? {2'b00, rmii_q} : rxd_in;
                mac_crs_q   <= crs_in;
                mac_col_q   <= col_in;
            end
        end
    end
    assign mac_rx_dv  = mac_rx_dv_q;
    assign mac_rx_er  = mac_rx_er_q;
    assign mac_rxd    = mac_rxd_q;
    assign mac_crs    = mac_crs_q;
    assign mac_col    = mac_col_q;
    assign mac_out_oe = oe_q;

    //////////////////////////////////////////////////////////////////////////
    // Transmit odd-nibble handling
    assign opt_bus.odd_det_dis = opt_b_q[ODD_DIS_BIT];
    assign opt_bus.tx_stb      = tx_stb;

    pco_tx_nibble u_tx_nibble (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .opt      (opt_bus.nib),
        .tx_en_in (tx_en_in),
        .tx_er_in (tx_er_in),
        .tx_en_q  (tx_en_out),
        .tx_er_q  (tx_er_out)
    );
endmodule // pco_top

//--- dv/pco_top_assertions.sv
module pco_chk
    import pco_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        ce,
    // Register bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    // Link
    input wire logic        an_mode,
    input wire logic        forced_100,
    input wire logic        partner_forced_100,
    input wire logic        ieee_full_duplex,
    input wire logic        link_up,
    input wire logic        link_100,
    input wire logic        pd_signal_ok,
    input wire logic        pd_link_ok,
    input wire logic        full_duplex,
    input wire logic        link_led,
    // Receive
    input wire logic        rx_sym_err,
    input wire logic        rx_idle,
    input wire logic        rmii_mode,
    input wire logic [1:0]  rmii_rxd_xi,
    input wire logic [1:0]  rmii_rxd_rxclk,
    input wire logic        mac_rx_dv,
    input wire logic        mac_rx_er,
    input wire logic [3:0]  mac_rxd,
    input wire logic        mac_crs,
    input wire logic        mac_col,
    input wire logic        mac_out_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        wr_q;
    logic [15:0] opt_q;
    logic        live, hold_on, ext_hit, std_hit, strict_on;
    logic        idle_hit, rmii_hit;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Shadow of option register B; bit 6 auto-set is not needed here
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_q  <= 1'b0;
            opt_q <= OPT_B_RST;
        end else if (ce && hready) begin
            wr_q <= hsel && htrans[1] && hwrite && hsize == 3'b010
                && haddr == {22'h0, IDX_OPT_B, 2'b00};
            if (wr_q) begin
                opt_q <= hwdata[15:0];
            end
        end
    end
    assign live      = ce && !rst;
    assign hold_on   = live && !opt_q[ISO_HD_BIT];
    assign ext_hit   = live && opt_q[EXT_FD_BIT] && partner_forced_100
                    && (an_mode || forced_100);
    assign std_hit   = live && !opt_q[EXT_FD_BIT];
    assign strict_on = live && opt_q[STRICT_BIT];
    assign idle_hit  = hold_on && opt_q[IDLE_ERR_BIT] && rx_sym_err && rx_idle;
    assign rmii_hit  = hold_on && rmii_mode;
    //////////////////////////////////////////////////////////////////////////
    property p_iso_zero;
        !mac_out_oe |-> {mac_rx_dv, mac_rx_er, mac_crs, mac_col,
            mac_rxd} == 8'h0;
    endproperty
    a_iso_zero: assert property (p_iso_zero)
        else $error("mac outputs active while isolated");
    property p_iso_keep;
        $past(hold_on) |-> mac_out_oe;
    endproperty
    a_iso_keep: assert property (p_iso_keep)
        else $error("mac outputs isolated with option clear");
    property p_ext_fd;
        $past(ext_hit) |-> full_duplex;
    endproperty
    a_ext_fd: assert property (p_ext_fd)
        else $error("half duplex against forced partner");
    property p_std_fd;
        $past(std_hit) |-> full_duplex == $past(ieee_full_duplex);
    endproperty
    a_std_fd: assert property (p_std_fd)
        else $error("duplex differs from standard resolution");
    property p_strict;
        $past(strict_on) && link_led |-> $past(link_100) && $past(link_up)
            && $past(full_duplex);
    endproperty
    a_strict: assert property (p_strict)
        else $error("indicator lit without 100 link");
    property p_idle_err;
        $past(idle_hit) |-> mac_rx_er;
    endproperty
    a_idle_err: assert property (p_idle_err)
        else $error("idle symbol error not reported");
    property p_rmii;
        $past(rmii_hit) && $past(live, 2) |-> mac_rxd[1:0] ==
            ($past(opt_q[RMII_CLK_BIT], 2) ? $past(rmii_rxd_rxclk, 2)
            : $past(rmii_rxd_xi, 2));
    endproperty
    a_rmii: assert property (p_rmii)
        else $error("reduced receive data from wrong reference");
    property p_pd_drop;
        pd_link_ok |-> $past(pd_signal_ok);
    endproperty
    a_pd_drop: assert property (p_pd_drop)
        else $error("parallel detect link held without signal");
endmodule // pco_chk

bind pco_top pco_chk u_chk (.*);

//--- dv/pco_mac_model.sv
module pco_mac_model #(
    parameter int TX_DIV = 10
)(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Transmit request
    output logic     tx_stb,
    output logic     tx_en_in,
    output logic     tx_er_in,
    // Transmit seen on the line side
    input wire logic tx_en_out,
    input wire logic tx_er_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int div_q = 0, en_cnt = 0, er_cnt = 0;
    initial begin
        tx_stb   = 1'b0;
        tx_en_in = 1'b0;
        tx_er_in = 1'b0;
    end
    // One strobe per nibble clock
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_q  <= 0;
            tx_stb <= 1'b0;
        end else begin
            div_q  <= (div_q == TX_DIV - 1) ? 0 : div_q + 1;
            tx_stb <= (div_q == TX_DIV - 1);
        end
    end
    always @(posedge core_clk) begin
        if (tx_stb) begin
            en_cnt <= en_cnt + int'(tx_en_out === 1'b1);
            er_cnt <= er_cnt + int'(tx_er_out === 1'b1);
        end
    end
    // Bounded wait for a strobe edge; a lost strobe spoils the count
    task automatic nib(inout bit ok);
        int i;
        i = 0;
        @(posedge core_clk);
        while (!tx_stb && i < 2 * TX_DIV) begin
            @(posedge core_clk);
            i++;
        end
        ok &= tx_stb;
    endtask
    // Deltas avoid racing the counters' own updates
    task automatic send(input int n, output int en, output int er);
        int e0;
        int r0;
        bit ok;
        ok = 1'b1;
        nib(ok);
        e0 = en_cnt;
        r0 = er_cnt;
        repeat (n) begin
            tx_en_in <= 1'b1;
            nib(ok);
        end
        tx_en_in <= 1'b0;
        repeat (4) nib(ok);
        en = ok ? en_cnt - e0 : -1;
        er = er_cnt - r0;
    endtask
endmodule // pco_mac_model

//--- dv/phy_control_two_options_test.sv
`define CHK(nm, e, g) begin \
    checks++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("mismatch %s exp %0h got %0h", nm, e, g); \
    end \
end
module phy_control_two_options_test
    import pco_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PD_N = 20;
    localparam int PD_F = 5;
    localparam logic [31:0] A_OPTA = {22'h0, IDX_OPT_A, 2'b00};
    localparam logic [31:0] A_OPTB = {22'h0, IDX_OPT_B, 2'b00};
    localparam logic [31:0] A_GEN  = {22'h0, IDX_GEN_CTL, 2'b00};
    logic        core_clk = 1'b0, rst = 1'b1, ce = 1'b1, hsel = 1'b0;
    logic        hwrite = 1'b0, pd_signal_ok = 1'b0, an_mode = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0]  htrans = '0, rmii_rxd_xi = '0, rmii_rxd_rxclk = '0;
    logic [2:0]  hsize = 3'h2;
    logic [3:0]  rxd_in = '0, mac_rxd;
    logic        hreadyout, hresp, pd_link_ok, full_duplex, link_led;
    logic        mac_rx_dv, mac_rx_er, mac_crs, mac_col, mac_out_oe;
    logic        tx_stb, tx_en_in, tx_er_in, tx_en_out, tx_er_out;
    logic        forced_100 = 1'b0, partner_forced_100 = 1'b0;
    logic        ieee_full_duplex = 1'b0, link_up = 1'b0, link_100 = 1'b0;
    logic        activity = 1'b0, rx_sym_err = 1'b0, rx_idle = 1'b0;
    logic        rx_dv_in = 1'b0, rx_er_in = 1'b0, crs_in = 1'b0;
    logic        col_in = 1'b0, rmii_mode = 1'b0;
    wire         hready = hreadyout;
    wire [7:0]   mac_vec = {mac_out_oe, mac_rx_dv, mac_crs, mac_col, mac_rxd};
    int          miscompares = 0, checks = 0, n, c, en, er;
    always #2 core_clk = ~core_clk;
    pco_top #(.PD_NORMAL_CYCLES(PD_N), .PD_FAST_CYCLES(PD_F),
        .BLINK_CYCLES(4)) dut (.*);
    pco_mac_model mac (.*);
    //////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (miscompares == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Look just before the edge, return just after it
    task automatic wait_rdy(output logic [31:0] rd);
        logic ok;
        ok = 1'b0;
        for (int i = 0; i < 50 && !ok; i++) begin
            @(negedge core_clk);
            ok = (hreadyout === 1'b1);
            rd = hrdata;
            @(posedge core_clk);
        end
        if (!ok) begin
            miscompares++;
            wrap_up();
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, d,
                        output logic [31:0] rd);
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        wait_rdy(rd);
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy(rd);
    endtask
    // Settles so registered effects are visible on return
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
        repeat (3) @(posedge core_clk);
    endtask
    task automatic rd_chk(input logic [31:0] a, e, input string nm);
        logic [31:0] x;
        xfer(1'b0, a, 32'h0, x);
        `CHK(nm, e, x)
        `CHK("hresp", 1'b0, hresp)
    endtask
    task automatic lit(output int k);
        k = 0;
        repeat (24) begin
            @(negedge core_clk);
            k += int'(link_led === 1'b1);
        end
        @(posedge core_clk);
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge core_clk);
        rst  <= 1'b0;
        hsel <= 1'b1;
        @(posedge core_clk);
        rd_chk(A_OPTB, {16'h0, OPT_B_RST}, "opt_b reset");
        wr(A_OPTB, 32'hdead_3f8a);
        rd_chk(A_OPTB, 32'h0000_3f8a, "opt_b readback");
        hsize <= 3'h1;
        wr(A_OPTB, 32'h0);
        hsize <= 3'h2;
        rd_chk(A_OPTB, 32'h0000_3f8a, "sub-word ignored");
        wr(32'h3c, 32'hffff_ffff);
        rd_chk(32'h3c, 32'h0, "unmapped");
        for (int m = 5; m < 7; m++) begin
            wr(A_OPTA, 32'h1 << m);
            wr(A_OPTB, 32'h0);
            rd_chk(A_OPTB, 32'h40, "fast pd auto");
        end
        wr(A_OPTA, 32'h0);
        wr(A_OPTB, 32'h0);
        rd_chk(A_OPTB, 32'h0, "fast pd clear");
        for (int f = 0; f < 2; f++) begin
            wr(A_OPTB, f ? 32'h40 : 32'h0);
            pd_signal_ok <= 1'b1;
            for (n = 0; n < 100; n++) begin
                @(negedge core_clk);
                if (pd_link_ok === 1'b1) break;
            end
            c = f ? PD_F : PD_N;
            `CHK("pd time", 1'b1, n >= c - 1 && n <= c + 2)
            @(posedge core_clk);
            pd_signal_ok <= 1'b0;
        end
        {partner_forced_100, link_up, link_100} <= 3'h7;
        for (int k = 0; k < 2; k++) begin
            {an_mode, forced_100} <= k ? 2'b01 : 2'b10;
            wr(A_OPTB, 32'h20);
            `CHK("ext fd", 1'b1, full_duplex)
        end
        for (int d = 0; d < 2; d++) begin
            ieee_full_duplex <= d[0];
            wr(A_OPTB, 32'h0);
            `CHK("std fd", d[0], full_duplex)
        end
        activity <= 1'b1;
        wr(A_GEN, 32'h1 << BLINK_BIT);
        wr(A_OPTB, 32'h10);
        lit(c);
        `CHK("strict steady", 24, c)
        link_100 <= 1'b0;
        wr(A_OPTB, 32'h10);
        lit(c);
        `CHK("strict 10", 0, c)
        wr(A_OPTB, 32'h0);
        lit(c);
        `CHK("blinking", 1'b1, c > 0 && c < 24)
        activity <= 1'b0;
        wr(A_OPTB, 32'h0);
        lit(c);
        `CHK("any link lit", 24, c)
        {link_100, ieee_full_duplex} <= 2'b10;
        {rx_dv_in, rx_er_in, crs_in, col_in, rxd_in} <= 8'hf9;
        wr(A_OPTB, 32'h8);
        `CHK("isolated", 8'h0, mac_vec)
        wr(A_OPTB, 32'h0);
        `CHK("driven", 8'hf9, mac_vec)
        {rx_er_in, rx_idle, rx_sym_err} <= 3'b011;
        for (int b = 0; b < 2; b++) begin
            wr(A_OPTB, b ? 32'h4 : 32'h0);
            `CHK("idle err", b[0], mac_rx_er)
        end
        {rmii_mode, rmii_rxd_xi, rmii_rxd_rxclk} <= 5'b1_01_10;
        for (int b = 0; b < 2; b++) begin
            wr(A_OPTB, b);
            `CHK("rmii rxd", b ? 2'b10 : 2'b01, mac_rxd[1:0])
        end
        for (int k = 0; k < 3; k++) begin
            wr(A_OPTB, (k == 2) ? 32'h2 : 32'h0);
            mac.send((k == 1) ? 4 : 3, en, er);
            `CHK("tx en len", (k == 1) ? 4 : 3 + int'(k == 0), en)
            `CHK("tx err", int'(k == 0), er)
        end
        wrap_up();
    end
endmodule // phy_control_two_options_test
